// ---- rtl/sra_spi_slave.sv ----
/*
 * SPI slave register access engine: page select, data window and access status,
 * with normal read, fast read and normal write over a mode 3 serial link.
 * Assumes the internal register file answers a fetch with reg_rd_valid on clk and
 * takes writes as single-cycle strobes; SCK is at most a few MHz against 50 MHz clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sra_spi_slave (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     ss_n,
   input  wire logic                     sck,
   input  wire logic                     mosi,
   output var  logic                     miso,
   output var  logic                     miso_oe,
   input  wire logic                     mdio_busy,
   output var  logic                     reg_rd_req,
   output var  logic                     reg_wr_req,
   output var  sra_pkg::sra_reg_req_type reg_req,
   input  wire logic                     reg_rd_valid,
   input  wire logic [63:0]              reg_rd_data
);

   logic                   rst_meta;
   logic                   rst_sync_n;
   logic [2:0]             pins;
   sra_pkg::sra_state_type st;
   sra_pkg::sra_state_type next_st;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Pins idle high for select and clock
   sra_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h6)
   ) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_sync_n),
      .async_in ({ss_n, sck, mosi}),
      .sync_out (pins)
   );

   logic       ss_s;
   logic       sck_s;
   logic       mosi_s;
   logic       sck_rise;
   logic       sck_fall;
   logic       cmd_ok;
   logic       cmd_write;
   logic       cmd_fast;
   logic [7:0] status_byte;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;

   assign ss_s   = pins[2];
   assign sck_s  = pins[1];
   assign mosi_s = pins[0];

   // Edge detection on the synchronised clock copy only
   assign sck_rise = sck_s & ~st.sck_prev;
   assign sck_fall = ~sck_s & st.sck_prev;

   // Command decode; fast write and foreign unit are ignored
   assign cmd_write = st.cmd[sra_pkg::CMD_DIR_BIT];
   assign cmd_fast  = st.cmd[sra_pkg::CMD_MODE_BIT];
   assign cmd_ok    = (st.cmd[3:1] == sra_pkg::CMD_UNIT_ID)
                    && (cmd_fast ? !cmd_write
                                 : st.cmd[7:5] == sra_pkg::CMD_NORMAL_TAG);

   // Status byte; done flag covers pending fetch and write strobe
   always_comb begin
      status_byte = 8'h00;
      status_byte[sra_pkg::STAT_XFER_DONE_BIT]  = st.busy | st.wr_req;
      status_byte[sra_pkg::STAT_READ_READY_BIT] = st.ready;
      status_byte[sra_pkg::STAT_MDIO_BIT]       = mdio_busy;
   end

   assign rx_byte = {st.rx_shift[6:0], mosi_s};

   // Byte to present at the start of each data byte
   always_comb begin
      tx_byte = 8'h00;
      if (st.phase == sra_pkg::PH_DATA && cmd_ok && !cmd_write) begin
         if (cmd_fast) begin
            if (st.fast_go) begin
               tx_byte = st.fast_data[{st.data_idx, 3'b000} +: 8];
            end else begin
               tx_byte[sra_pkg::FAST_READY_BIT] = st.fast_ready;
            end
         end else begin
            case (st.addr)
               sra_pkg::ADDR_STATUS:      tx_byte = status_byte;
               sra_pkg::ADDR_PAGE:        tx_byte = st.page;
               sra_pkg::ADDR_DATA_WINDOW: tx_byte = st.window[{st.data_idx, 3'b000} +: 8];
               default:                   tx_byte = 8'h00;
            endcase
         end
      end
   end

   // Next-state logic of the whole engine
   always_comb begin
      next_st          = st;
      next_st.sck_prev = sck_s;
      next_st.rd_req   = 1'b0;
      next_st.wr_req   = 1'b0;

      // Fetch answer from the register file
      if (reg_rd_valid && st.busy) begin
         next_st.busy = 1'b0;
         if (st.fetch_fast) begin
            next_st.fast_data  = reg_rd_data;
            next_st.fast_ready = 1'b1;
         end else begin
            next_st.window = reg_rd_data;
            next_st.ready  = 1'b1;
         end
      end

      // Frame boundaries follow the select line alone
      if (ss_s) begin
         next_st.phase    = sra_pkg::PH_IDLE;
         next_st.bit_cnt  = 3'h0;
         next_st.tx_shift = 8'h00;
         next_st.fast_go  = 1'b0;
         next_st.fast_arm = 1'b0;
      end else if (st.phase == sra_pkg::PH_IDLE) begin
         next_st.phase    = sra_pkg::PH_CMD;
         next_st.bit_cnt  = 3'h0;
         next_st.data_idx = 3'h0;
      end else begin
         // Falling edge: present the next bit, a fresh byte on bit zero
         if (sck_fall) begin
            if (st.bit_cnt == 3'h0) begin
               next_st.tx_shift = tx_byte;
               // Ready is judged as the status byte is loaded, ahead of its bit 0
               if (st.phase == sra_pkg::PH_DATA && cmd_fast && !st.fast_go) begin
                  next_st.fast_arm = st.fast_ready;
               end
            end else begin
               next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
            end
         end

         // Rising edge: sample MOSI, act on each completed byte
         if (sck_rise) begin
            next_st.rx_shift = rx_byte;
            next_st.bit_cnt  = st.bit_cnt + 3'h1;
            if (st.bit_cnt == sra_pkg::LAST_BIT) begin
               case (st.phase)
                  sra_pkg::PH_CMD: begin
                     next_st.cmd   = rx_byte;
                     next_st.phase = sra_pkg::PH_ADDR;
                  end
                  sra_pkg::PH_ADDR: begin
                     next_st.addr     = rx_byte;
                     next_st.phase    = sra_pkg::PH_DATA;
                     next_st.data_idx = cmd_fast ? st.cmd[7:5] : 3'h0;
                     // Fast read fetches as soon as the offset arrives
                     if (cmd_ok && cmd_fast) begin
                        next_st.rd_req      = 1'b1;
                        next_st.busy        = 1'b1;
                        next_st.fetch_fast  = 1'b1;
                        next_st.fast_ready  = 1'b0;
                        next_st.req.page    = st.page;
                        next_st.req.offset  = rx_byte;
                        next_st.req.data    = 8'h00;
                     end
                  end
                  sra_pkg::PH_DATA: begin
                     if (cmd_ok && cmd_write) begin
                        if (st.addr == sra_pkg::ADDR_PAGE) begin
                           next_st.page = rx_byte;
                        end else if (st.addr == sra_pkg::ADDR_DATA_WINDOW) begin
                           next_st.window[{st.data_idx, 3'b000} +: 8] = rx_byte;
                        end else if (st.addr != sra_pkg::ADDR_STATUS) begin
                           // Byte write into the selected page
                           next_st.wr_req     = 1'b1;
                           next_st.req.page   = st.page;
                           next_st.req.offset = st.addr + {5'h00, st.data_idx};
                           next_st.req.data   = rx_byte;
                        end
                        next_st.data_idx = st.data_idx + 3'h1;
                     end else if (cmd_ok && cmd_fast) begin
                        if (st.fast_go) begin
                           next_st.data_idx = st.data_idx + 3'h1;
                        end
                        if (st.fast_arm) begin
                           next_st.fast_go = 1'b1;
                        end
                     end else if (cmd_ok) begin
                        // Dummy byte of an indirect read starts the fetch, and again each time data_idx wraps to 0
                        if (st.addr != sra_pkg::ADDR_STATUS && st.addr != sra_pkg::ADDR_PAGE
                            && st.addr != sra_pkg::ADDR_DATA_WINDOW
                            && st.data_idx == 3'h0) begin
                           next_st.rd_req     = 1'b1;
                           next_st.busy       = 1'b1;
                           next_st.fetch_fast = 1'b0;
                           next_st.req.page   = st.page;
                           next_st.req.offset = st.addr;
                           next_st.req.data   = 8'h00;
                           // A set in this cycle from a previous fetch is superseded
                           next_st.ready      = 1'b0;
                        end
                        next_st.data_idx = st.data_idx + 3'h1;
                     end
                  end
                  default: begin
                     next_st.phase = sra_pkg::PH_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // Single register for all state
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st.phase      <= sra_pkg::PH_IDLE;
         st.bit_cnt    <= 3'h0;
         st.rx_shift   <= 8'h00;
         st.tx_shift   <= 8'h00;
         st.cmd        <= 8'h00;
         st.addr       <= 8'h00;
         st.data_idx   <= 3'h0;
         st.page       <= sra_pkg::PAGE_RESET;
         st.window     <= sra_pkg::WINDOW_RESET;
         st.fast_data  <= sra_pkg::WINDOW_RESET;
         st.busy       <= 1'b0;
         st.ready      <= 1'b0;
         st.fast_ready <= 1'b0;
         st.fast_arm   <= 1'b0;
         st.fast_go    <= 1'b0;
         st.fetch_fast <= 1'b0;
         st.sck_prev   <= 1'b1;
         st.rd_req     <= 1'b0;
         st.wr_req     <= 1'b0;
         st.req        <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign miso       = st.tx_shift[7];
   assign miso_oe    = (st.phase != sra_pkg::PH_IDLE);
   assign reg_rd_req = st.rd_req;
   assign reg_wr_req = st.wr_req;
   assign reg_req    = st.req;

endmodule : sra_spi_slave

`default_nettype wire

// ---- rtl/sra_pkg.sv ----
/*
 * Shared constants, types and state layout of the SPI register access slave.
 * Assumes a single 50 MHz core clock; the serial clock is sampled, not used as a clock.
 */
package sra_pkg;

   // Interface register offsets in the global page
   localparam logic [7:0] ADDR_DATA_WINDOW = 8'hF0;
   localparam logic [7:0] ADDR_STATUS      = 8'hFE;
   localparam logic [7:0] ADDR_PAGE        = 8'hFF;

   // Status register bit positions, then the ready bit of the fast read status byte
   localparam int STAT_XFER_DONE_BIT  = 7;
   localparam int STAT_READ_READY_BIT = 5;
   localparam int STAT_MDIO_BIT       = 2;
   localparam int FAST_READY_BIT      = 0;

   // Command byte fields
   localparam int         CMD_DIR_BIT   = 0;
   localparam int         CMD_MODE_BIT  = 4;
   localparam logic [2:0] CMD_NORMAL_TAG = 3'h3;
   localparam logic [2:0] CMD_UNIT_ID    = 3'h0;

   // Reset values and sizes
   localparam logic [7:0]  PAGE_RESET   = 8'h00;
   localparam logic [63:0] WINDOW_RESET = 64'h0000_0000_0000_0000;
   localparam int          WINDOW_BYTES = 8;
   localparam logic [2:0]  LAST_BIT     = 3'h7;

   // Frame phase, one-hot
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_CMD  = 4'b0010,
      PH_ADDR = 4'b0100,
      PH_DATA = 4'b1000
   } sra_phase_type;

   // Request towards the internal register file
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] offset;
      logic [7:0] data;
   } sra_reg_req_type;

   // Whole state of the engine
   typedef struct packed {
      sra_phase_type   phase;
      logic [2:0]      bit_cnt;
      logic [7:0]      rx_shift;
      logic [7:0]      tx_shift;
      logic [7:0]      cmd;
      logic [7:0]      addr;
      logic [2:0]      data_idx;
      logic [7:0]      page;
      logic [63:0]     window;
      logic [63:0]     fast_data;
      logic            busy;
      logic            ready;
      logic            fast_ready;
      logic            fast_arm;
      logic            fast_go;
      logic            fetch_fast;
      logic            sck_prev;
      logic            rd_req;
      logic            wr_req;
      sra_reg_req_type req;
   } sra_state_type;

endpackage : sra_pkg

// ---- rtl/sra_sync.sv ----
/*
 * Two flip-flop synchroniser for a bundle of level inputs.
 * Assumes inputs are asynchronous to clk; only the second stage may be read.
 */
`timescale 1ns/1ps
`default_nettype none

module sra_sync #(
   parameter int             WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : sra_sync

`default_nettype wire

// ---- sim/sra_regfile_model.sv ----
/* Register file stand-in behind the slave's fetch strobe.
 * Assumes one clock domain; answers 3 or 401 clk after the strobe as slow asks. */
`timescale 1ns/1ps
`default_nettype none
module sra_regfile_model (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     slow,
   input  wire logic                     rd_req,
   input  wire sra_pkg::sra_reg_req_type req,
   output var  logic                     rd_valid,
   output var  logic [63:0]              rd_data
);
   logic       busy;
   logic [7:0] off;
   logic [8:0] cnt;
   // Byte i of a fetch is offset plus i; data churns outside the answer
   // cycle so a slave that samples late sees garbage, not a lucky value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         off      <= 8'h00;
         cnt      <= 9'h000;
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else begin
         rd_valid <= 1'b0;
         rd_data  <= ~rd_data;
         if (rd_req) begin
            busy <= 1'b1;
            off  <= req.offset;
            cnt  <= slow ? 9'h190 : 9'h002;
         end else if (busy && cnt != 9'h000) begin
            cnt <= cnt - 9'h001;
         end else if (busy) begin
            busy     <= 1'b0;
            rd_valid <= 1'b1;
            for (int i = 0; i < 8; i++) begin
               rd_data[8*i+:8] <= off + 8'(i);
            end
         end
      end
   end
endmodule : sra_regfile_model
`default_nettype wire

// ---- sim/sra_spi_slave_asserts.sv ----
/* Port assertions of the SPI register access slave.
 * Assumes SCK halves of 4 clk and select gaps of several clk. */
`timescale 1ns/1ps
`default_nettype none
module sra_spi_slave_asserts (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     ss_n,
   input wire logic                     sck,
   input wire logic                     miso,
   input wire logic                     miso_oe,
   input wire logic                     reg_rd_req,
   input wire logic                     reg_wr_req,
   input wire sra_pkg::sra_reg_req_type reg_req
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Pin quiet once select has been high a while
   a_oe_idle: assert property (ss_n [*5] |-> !miso_oe && !miso)
      else $error("miso driven outside a frame");
   a_oe_frame: assert property (!ss_n [*4] |-> miso_oe)
      else $error("miso not driven in a frame");
   // No access starts without a frame
   a_quiet_idle: assert property (ss_n [*6] |-> !reg_rd_req && !reg_wr_req)
      else $error("strobe outside a frame");
   a_strobe_framed: assert property ((reg_rd_req || reg_wr_req) |-> miso_oe && !ss_n)
      else $error("strobe without active frame");
   // Strobes are single pulses, never both at once
   a_wr_pulse: assert property (reg_wr_req |=> !reg_wr_req)
      else $error("write strobe too long");
   a_rd_pulse: assert property (reg_rd_req |=> !reg_rd_req)
      else $error("fetch strobe too long");
   a_rd_wr_excl: assert property (!(reg_rd_req && reg_wr_req))
      else $error("fetch and write together");
   a_req_hold: assert property (reg_wr_req |=> $stable(reg_req) [*4])
      else $error("request fields moved after strobe");
   // Data only moves after a falling edge, so it holds while SCK is high
   a_miso_hold: assert property (!ss_n && !$past(ss_n, 8) && sck && $past(sck, 3)
                                 |-> $stable(miso))
      else $error("miso changed while sck high");
endmodule : sra_spi_slave_asserts
bind sra_spi_slave sra_spi_slave_asserts chk_u (
   .clk        (clk),
   .rst_n      (rst_n),
   .ss_n       (ss_n),
   .sck        (sck),
   .miso       (miso),
   .miso_oe    (miso_oe),
   .reg_rd_req (reg_rd_req),
   .reg_wr_req (reg_wr_req),
   .reg_req    (reg_req)
);
`default_nettype wire

// ---- sim/sra_spi_slave_tb.sv ----
/* Bench for the SPI register access slave: mode 3 frames from the host.
 * Assumes the register file model answers fetches beside the design. */
`timescale 1ns/1ps
`default_nettype none
module sra_spi_slave_tb;
   logic                     clk, rst_n, ss_n, sck, mosi, mdio_busy, slow;
   logic                     miso, miso_oe, rd_req, wr_req, rd_valid;
   logic [63:0]              rd_data;
   sra_pkg::sra_reg_req_type req, rd_log;
   sra_pkg::sra_reg_req_type wr_log [$];
   logic [7:0]               tx [10];
   logic [7:0]               rx [10];
   logic [7:0]               st;
   logic [7:0]               bad [3] = '{8'h63, 8'h41, 8'h11};
   int                       n_mismatch, samples_checked;

   sra_spi_slave dut_u (
      .clk          (clk),
      .rst_n        (rst_n),
      .ss_n         (ss_n),
      .sck          (sck),
      .mosi         (mosi),
      .miso         (miso),
      .miso_oe      (miso_oe),
      .mdio_busy    (mdio_busy),
      .reg_rd_req   (rd_req),
      .reg_wr_req   (wr_req),
      .reg_req      (req),
      .reg_rd_valid (rd_valid),
      .reg_rd_data  (rd_data)
   );
   sra_regfile_model model_u (
      .clk      (clk),
      .rst_n    (rst_n),
      .slow     (slow),
      .rd_req   (rd_req),
      .req      (req),
      .rd_valid (rd_valid),
      .rd_data  (rd_data)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Strobes logged on the falling edge, clear of rising-edge updates
   always @(negedge clk) begin
      if (rd_req === 1'b1) rd_log = req;
      if (wr_req === 1'b1) wr_log.push_back(req);
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // Host drives on the falling edge; reads late in the high half, where
   // the slave's output has long settled
   task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
      for (int b = 7; b >= 0; b--) begin
         sck  <= 1'b0;
         mosi <= t[b];
         cyc(4);
         sck <= 1'b1;
         cyc(3);
         r[b] = miso;
         cyc(1);
      end
   endtask : xbyte
   task automatic open_f;
      ss_n <= 1'b0;
      cyc(3);
   endtask : open_f
   task automatic close_f;
      cyc(2);
      ss_n <= 1'b1;
      mosi <= ~mosi;
      cyc(6);
   endtask : close_f
   task automatic frame(input int n);
      open_f();
      for (int k = 0; k < n; k++) xbyte(tx[k], rx[k]);
      close_f();
   endtask : frame
   task automatic f3(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
      tx[0] = c;
      tx[1] = a;
      tx[2] = d;
      frame(3);
      st = rx[2];
   endtask : f3
   // Status polled until the flags in m are set, bounded
   task automatic poll(input logic [7:0] m);
      for (int k = 0; k < 20; k++) begin
         f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
         if ((st & m) === m) return;
      end
      n_mismatch++;
      test_done();
   endtask : poll

   initial begin
      cyc(90000);
      n_mismatch++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      ss_n = 1'b1;
      sck = 1'b1;
      mosi = 1'b0;
      mdio_busy = 1'b0;
      slow = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      foreach (tx[k]) tx[k] = 8'h00;
      cyc(10);
      rst_n <= 1'b1;
      cyc(8);
      // Idle status, then the management flag shown live
      f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
      chk(st, 8'h00);
      mdio_busy <= 1'b1;
      f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
      chk(st, 8'h04);
      mdio_busy <= 1'b0;
      $display("status test done");
      // Page written once and kept across other frames
      f3(8'h61, sra_pkg::ADDR_PAGE, 8'h10);
      f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
      f3(8'h60, sra_pkg::ADDR_PAGE, 8'h00);
      chk(st, 8'h10);
      // Dummy byte starts the fetch; window then read low byte first
      f3(8'h60, 8'h12, 8'h00);
      chk(64'(rd_log), 64'h10_1200);
      poll(8'h20);
      chk(st, 8'h20);
      tx[0] = 8'h60;
      tx[1] = sra_pkg::ADDR_DATA_WINDOW;
      frame(10);
      for (int k = 0; k < 8; k++) chk(rx[k+2], 8'h12 + 8'(k));
      $display("normal read test done");
      // A new trigger drops the old ready flag while a slow fetch runs
      slow <= 1'b1;
      f3(8'h60, 8'h13, 8'h00);
      f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
      chk(st, 8'h80);
      poll(8'h20);
      // Burst write: one strobe a byte, offset counting up
      wr_log.delete();
      tx[0] = 8'h61;
      tx[1] = 8'h34;
      tx[2] = 8'hAB;
      tx[3] = 8'hCD;
      frame(4);
      chk(64'(wr_log[0]), 64'h10_34AB);
      chk(64'(wr_log[1]), 64'h10_35CD);
      // Foreign unit, bad tag and fast write leave no trace
      foreach (bad[k]) begin
         f3(bad[k], 8'h34, 8'h55);
         f3(bad[k], sra_pkg::ADDR_PAGE, 8'h55);
      end
      chk(64'(wr_log.size()), 64'h2);
      f3(8'h60, sra_pkg::ADDR_PAGE, 8'h00);
      chk(st, 8'h10);
      $display("write test done");
      // Fast read at byte offset 2: status bytes until bit 0, then data
      open_f();
      xbyte(8'h50, st);
      xbyte(8'h12, st);
      // Each status byte is judged whole, ready bit read before the next byte is clocked
      for (int k = 0; k < 12 && st !== 8'h01; k++) xbyte(8'h00, st);
      chk(st, 8'h01);
      xbyte(8'h00, st);
      chk(st, 8'h14);
      xbyte(8'h00, st);
      chk(st, 8'h15);
      close_f();
      f3(8'h60, sra_pkg::ADDR_STATUS, 8'h00);
      chk(st, 8'h20);
      $display("fast read test done");
      test_done();
   end
endmodule : sra_spi_slave_tb
`default_nettype wire
